// >>> hw/nmf_pkg.sv
// constants shared by the navigation message framer
// Contract
// - data leaves at 50 bit/s, rate one-half coded, so 100 symbols/s
// - every message is exactly 300 bits, a six-second slot
// - each message ends in a 24-bit crc block over the message content
// - type 0 is the default; a failed message is replaced by it
// - a slot with no type assigned carries the default message
// - every message opens with the 8-bit preamble 10001011
// - a 6-bit transmitter identifier follows the preamble
// - a 6-bit message type follows the identifier, values 0 to 63
// - 17-bit time-of-week count of the next message start, units of 6 s
// - bit 38 is the alert flag
// - default message bits 39 to 276 alternate one-zero, crc still appended
package nmf_pkg;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned DATA_RATE_BPS = 50;
    localparam int unsigned FEC_SYM_PER_BIT = 2;
    localparam int unsigned SYM_RATE_SPS = DATA_RATE_BPS * FEC_SYM_PER_BIT;
    localparam int unsigned SYM_PERIOD_US = 1000000 / SYM_RATE_SPS;
    localparam int unsigned SYM_CYC_DEF = SYM_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned SYM_CNT_W = 20;

    localparam int unsigned MSG_BITS = 300;
    localparam int unsigned CRC_BITS = 24;
    localparam int unsigned BODY_BITS = MSG_BITS - CRC_BITS;
    localparam int unsigned PAYLOAD_BITS = 238;
    localparam int unsigned BIT_IDX_W = 9;
    localparam logic [BIT_IDX_W-1:0] LAST_BODY_IDX = 9'h113;
    localparam logic [BIT_IDX_W-1:0] LAST_MSG_IDX = 9'h12b;

    localparam logic [7:0] PREAMBLE = 8'h8b;
    localparam logic [5:0] DEFAULT_TYPE = 6'h00;
    localparam logic [PAYLOAD_BITS-1:0] DEFAULT_FILL = {119{2'b10}};

    localparam logic [CRC_BITS-1:0] CRC_POLY = 24'h864cfb;
    localparam logic [CRC_BITS-1:0] CRC_INIT = 24'h000000;
    localparam logic [6:0] FEC_G1 = 7'h79;
    localparam logic [6:0] FEC_G2 = 7'h5b;

    typedef enum logic [1:0] {
        NMF_LOAD,
        NMF_BODY,
        NMF_CRC
    } nmf_state_t;
endpackage

// >>> hw/nmf_buf2.sv
// two-entry symbol buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module nmf_buf2 #(
    parameter int unsigned W = 1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] head_reg;
    logic [W-1:0] tail_reg;
    logic head_vld_reg;
    logic tail_vld_reg;
    wire push = in_valid & ~tail_vld_reg;
    wire pop = head_vld_reg & out_ready;

    assign in_ready = ~tail_vld_reg;
    assign out_valid = head_vld_reg;
    assign out_data = head_reg;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            head_reg <= '0;
            tail_reg <= '0;
            head_vld_reg <= 1'b0;
            tail_vld_reg <= 1'b0;
        end else if (pop) begin
            // head drains; the tail or a fresh word moves up
            head_reg <= tail_vld_reg ? tail_reg : in_data;
            head_vld_reg <= tail_vld_reg | push;
            tail_vld_reg <= 1'b0;
        end else if (push && !head_vld_reg) begin
            head_reg <= in_data;
            head_vld_reg <= 1'b1;
        end else if (push) begin
            tail_reg <= in_data;
            tail_vld_reg <= 1'b1;
        end
    end
endmodule // nmf_buf2
`default_nettype wire

// >>> hw/nmf_framer.sv
// navigation message framer: header, payload, crc and rate one-half coding
`timescale 1ns/1ps
`default_nettype none
module nmf_framer
    import nmf_pkg::*;
#(
    parameter int unsigned SYM_CYC = SYM_CYC_DEF
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [5:0] prn_id,
    input wire logic [16:0] tow_next,
    input wire logic alert,
    input wire logic slot_assigned,
    input wire logic slot_fail,
    input wire logic [5:0] slot_type,
    input wire logic [PAYLOAD_BITS-1:0] slot_payload,
    input wire logic sym_ready,
    output logic sym_data,
    output logic sym_valid,
    output logic msg_take,
    output logic [5:0] sent_type,
    output logic sent_default
);
    nmf_state_t state_reg;
    nmf_state_t state_next;
    logic [SYM_CNT_W-1:0] tick_cnt_reg;
    logic pend_reg;
    logic phase_reg;
    logic g2_hold_reg;
    logic [BIT_IDX_W-1:0] bit_idx_reg;
    logic [BODY_BITS-1:0] body_reg;
    logic [CRC_BITS-1:0] crc_reg;
    logic [5:0] conv_reg;
    logic msg_take_reg;
    logic [5:0] sent_type_reg;
    logic sent_default_reg;
    logic buf_ready;

    // symbol pacing: one symbol slot every SYM_CYC clocks
    wire tick = (tick_cnt_reg == SYM_CNT_W'(SYM_CYC - 1));
    wire in_load = (state_reg == NMF_LOAD);
    wire in_body = (state_reg == NMF_BODY);
    wire in_crc = (state_reg == NMF_CRC);
    wire sending = in_body | in_crc;
    wire emit = pend_reg & sending & buf_ready;
    // first symbol of a bit moves shifter, crc and coder; the second closes the bit
    wire first_sym = emit & ~phase_reg;
    wire bit_done = emit & phase_reg;
    wire body_end = bit_done & (bit_idx_reg == LAST_BODY_IDX);
    wire msg_end = bit_done & (bit_idx_reg == LAST_MSG_IDX);

    // default replaces a failed or unassigned slot
    wire use_default = ~slot_assigned | slot_fail;
    wire [5:0] load_type = use_default ? DEFAULT_TYPE : slot_type;
    wire [PAYLOAD_BITS-1:0] load_pay = use_default ? DEFAULT_FILL : slot_payload;
    // header fields after the preamble, one wire each
    wire [5:0] hdr_id = prn_id;
    wire [5:0] hdr_type = load_type;
    wire [16:0] hdr_tow = tow_next;
    wire hdr_alert = alert;
    // transmission order, msb first
    wire [BODY_BITS-1:0] load_body = {PREAMBLE, hdr_id, hdr_type, hdr_tow, hdr_alert,
        load_pay};

    // current data bit: body first, then the crc remainder
    wire cur_bit = in_crc ? crc_reg[CRC_BITS-1] : body_reg[BODY_BITS-1];
    wire crc_fb = crc_reg[CRC_BITS-1] ^ cur_bit;
    wire [CRC_BITS-1:0] crc_shift = {crc_reg[CRC_BITS-2:0], 1'b0};
    wire [CRC_BITS-1:0] crc_upd = crc_fb ? (crc_shift ^ CRC_POLY) : crc_shift;
    wire [BODY_BITS-1:0] body_shift = {body_reg[BODY_BITS-2:0], 1'b0};
    wire [CRC_BITS-1:0] crc_step = in_body ? crc_upd : crc_shift;
    wire [6:0] conv_win = {cur_bit, conv_reg};
    wire g1 = ^(conv_win & FEC_G1);
    wire g2 = ^(conv_win & FEC_G2);
    wire buf_data = phase_reg ? g2_hold_reg : g1;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            NMF_LOAD: state_next = NMF_BODY;
            NMF_BODY: begin
                if (body_end) begin
                    state_next = NMF_CRC;
                end
            end
            NMF_CRC: begin
                if (msg_end) begin
                    state_next = NMF_LOAD;
                end
            end
            default: state_next = NMF_LOAD;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= NMF_LOAD;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
        end
    end

    // a tick while one is already waiting merges with it
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= tick | (pend_reg & ~emit);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= 1'b0;
        end else if (in_load) begin
            phase_reg <= 1'b0;
        end else if (emit) begin
            phase_reg <= ~phase_reg;
        end
    end

    // second symbol of a bit comes from the window captured with the first
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            g2_hold_reg <= 1'b0;
        end else if (first_sym) begin
            g2_hold_reg <= g2;
        end
    end

    // bit count over the whole message: body bits, then crc bits
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bit_idx_reg <= '0;
        end else if (in_load) begin
            bit_idx_reg <= '0;
        end else if (bit_done) begin
            bit_idx_reg <= bit_idx_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            body_reg <= '0;
        end else if (in_load) begin
            body_reg <= load_body;
        end else if (first_sym && in_body) begin
            body_reg <= body_shift;
        end
    end

    // crc clears per message; in the crc phase it only shifts its remainder out
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            crc_reg <= CRC_INIT;
        end else if (in_load) begin
            crc_reg <= CRC_INIT;
        end else if (first_sym) begin
            crc_reg <= crc_step;
        end
    end

    // coder memory runs on across messages
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            conv_reg <= '0;
        end else if (first_sym) begin
            conv_reg <= conv_win[6:1];
        end
    end

    // message-taken pulse, high for the one cycle after the load cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            msg_take_reg <= 1'b0;
        end else begin
            msg_take_reg <= in_load;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sent_type_reg <= DEFAULT_TYPE;
        end else if (in_load) begin
            sent_type_reg <= load_type;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sent_default_reg <= 1'b0;
        end else if (in_load) begin
            sent_default_reg <= use_default;
        end
    end

    // stall by the receiver holds the coder, nothing is dropped
    nmf_buf2 #(
        .W(1)
    ) u_buf (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(emit),
        .in_ready(buf_ready),
        .in_data(buf_data),
        .out_valid(sym_valid),
        .out_ready(sym_ready),
        .out_data(sym_data)
    );

    assign msg_take = msg_take_reg;
    assign sent_type = sent_type_reg;
    assign sent_default = sent_default_reg;
endmodule // nmf_framer
`default_nettype wire

// >>> verification/nmf_monitor.sv
// port checker for the navigation message framer
`timescale 1ns/1ps
`default_nettype none
module nmf_monitor (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic slot_assigned,
    input wire logic slot_fail,
    input wire logic [5:0] slot_type,
    input wire logic sym_ready,
    input wire logic sym_data,
    input wire logic sym_valid,
    input wire logic msg_take,
    input wire logic [5:0] sent_type,
    input wire logic sent_default
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_fail_load;
        slot_fail ##1 msg_take;
    endsequence
    sequence s_idle_load;
        !slot_assigned ##1 msg_take;
    endsequence
    sequence s_good_load;
        (slot_assigned && !slot_fail) ##1 msg_take;
    endsequence
    a_fail_default: assert property (s_fail_load |-> sent_default)
        else $error("failed slot not defaulted");
    a_idle_default: assert property (s_idle_load |-> sent_default)
        else $error("idle slot not defaulted");
    a_type_passed: assert property (
        s_good_load |-> !sent_default && sent_type == $past(slot_type))
        else $error("type not passed");
    a_default_zero: assert property (sent_default |-> sent_type == 6'h00)
        else $error("default type not zero");
    a_take_single: assert property (msg_take |=> !msg_take [*8])
        else $error("load pulse too long");
    a_type_steady: assert property (!msg_take |-> $stable(sent_type))
        else $error("type moved between loads");
    a_sym_hold: assert property (
        sym_valid && !sym_ready |=> sym_valid && $stable(sym_data))
        else $error("symbol dropped while stalled");
    a_valid_drop: assert property ($fell(sym_valid) |-> $past(sym_ready))
        else $error("valid fell untaken");
endmodule // nmf_monitor
bind nmf_framer nmf_monitor nmf_monitor_i (.mclk(mclk), .nrst(nrst), .slot_assigned(slot_assigned),
    .slot_fail(slot_fail), .slot_type(slot_type), .sym_ready(sym_ready), .sym_data(sym_data),
    .sym_valid(sym_valid), .msg_take(msg_take), .sent_type(sent_type), .sent_default(sent_default));
`default_nettype wire

// >>> verification/nmf_rx.sv
// receiver model that collects coded symbols and stalls on request
`timescale 1ns/1ps
`default_nettype none
module nmf_rx (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic stall,
    input wire logic sym_data,
    input wire logic sym_valid,
    output logic sym_ready
);
    logic got[$];
    assign sym_ready = !stall;
    always @(posedge mclk)
        if (nrst && sym_valid && sym_ready) got.push_back(sym_data);
endmodule // nmf_rx
`default_nettype wire

// >>> verification/test_nav_message_framer.sv
// testbench for the navigation message framer
`timescale 1ns/1ps
`default_nettype none
module test_nav_message_framer;
    import nmf_pkg::*;
    logic mclk, nrst, alert, slot_assigned, slot_fail, stall, sym_ready, sym_data, sym_valid;
    logic msg_take, sent_default;
    logic [5:0] prn_id, slot_type, sent_type, cst;
    logic [16:0] tow_next;
    logic [PAYLOAD_BITS-1:0] slot_payload;
    logic exp_q[$];
    int failures, n_tests, ci;
    nmf_framer #(.SYM_CYC(4)) nmf_framer_i (.mclk(mclk), .nrst(nrst), .prn_id(prn_id),
        .tow_next(tow_next), .alert(alert), .slot_assigned(slot_assigned), .slot_fail(slot_fail),
        .slot_type(slot_type), .slot_payload(slot_payload), .sym_ready(sym_ready),
        .sym_data(sym_data), .sym_valid(sym_valid), .msg_take(msg_take), .sent_type(sent_type),
        .sent_default(sent_default));
    nmf_rx nmf_rx_i (.mclk(mclk), .nrst(nrst), .stall(stall), .sym_data(sym_data),
        .sym_valid(sym_valid), .sym_ready(sym_ready));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp_syms();
        while (ci < nmf_rx_i.got.size()) begin
            check("sym", nmf_rx_i.got[ci], exp_q[ci]);
            ci++;
        end
    endtask
    // next message set up while the last one still has three symbols to send
    task automatic run_msg(logic [5:0] typ, logic alrt, logic asg, logic fl, logic [16:0] tow);
        logic [299:0] fr;
        logic [23:0] c;
        logic [6:0] w;
        logic dflt;
        int k;
        @(negedge mclk);
        {slot_type, alert, slot_assigned, slot_fail, tow_next} = {typ, alrt, asg, fl, tow};
        stall = 1'b0;
        k = 0;
        while (!msg_take && k < 5000) begin
            @(negedge mclk);
            k++;
        end
        dflt = !asg || fl;
        check("take", msg_take, 1'b1);
        check("type", sent_type, dflt ? 6'h00 : typ);
        check("dflt", sent_default, dflt);
        @(negedge mclk);
        stall = 1'b1;
        repeat (40) @(negedge mclk);
        stall = 1'b0;
        fr[299:24] = {8'h8b, prn_id, dflt ? 6'h00 : typ, tow, alrt,
            dflt ? {119{2'b10}} : slot_payload};
        c = 24'h0;
        for (int i = 299; i >= 24; i--)
            c = {c[22:0], 1'b0} ^ ((c[23] ^ fr[i]) ? 24'h864cfb : 24'h0);
        fr[23:0] = c;
        for (int i = 299; i >= 0; i--) begin
            w = {fr[i], cst};
            exp_q.push_back(^(w & 7'h79));
            exp_q.push_back(^(w & 7'h5b));
            cst = w[6:1];
        end
        while (nmf_rx_i.got.size() < exp_q.size() - 3 && k < 9000) begin
            @(negedge mclk);
            k++;
        end
        stall = 1'b1;
        cmp_syms();
    endtask
    task automatic t_unassigned();
        run_msg(6'h15, 1'b0, 1'b0, 1'b0, 17'h1ffff);
    endtask
    task automatic t_alert_top();
        run_msg(6'h3f, 1'b1, 1'b1, 1'b0, 17'h00001);
    endtask
    task automatic t_fail();
        run_msg(6'h0a, 1'b1, 1'b1, 1'b1, 17'h0a5a5);
    endtask
    initial begin
        #(20 * 30000);
        failures++;
        wrap_up();
    end
    initial begin
        {nrst, stall, alert, slot_assigned, slot_fail} = 5'h0;
        prn_id = 6'h2a;
        slot_type = 6'h15;
        tow_next = 17'h1ffff;
        slot_payload = {14{17'h1a5c3}};
        {failures, n_tests, ci} = '0;
        cst = 6'h0;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        t_unassigned();
        t_alert_top();
        t_fail();
        @(negedge mclk);
        stall = 1'b0;
        // drain the last message only, before the next one starts to flow
        repeat (100) if (nmf_rx_i.got.size() < 1800) @(negedge mclk);
        stall = 1'b1;
        cmp_syms();
        check("count", nmf_rx_i.got.size(), 32'd1800);
        wrap_up();
    end
endmodule // test_nav_message_framer
`default_nettype wire
